// [rtl/flash_pe_pkg.sv]
// Purpose: Shared constants and types for the flash program/erase control block.
// Assumes: AXI4-Lite register access with 32-bit data, one clock domain.
// Notes:   Every offset, control bit position and the control reset value used by the logic live here; the status mode field at bits 2:0 does not.
package flash_pe_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00; // Request, check and guard bits.
    localparam logic [7:0] OFF_CTRL_SECOND = 8'h04; // Error flag, read only.
    localparam logic [7:0] OFF_EBS_FIRST   = 8'h08; // Erase block select, blocks 7..0.
    localparam logic [7:0] OFF_EBS_SECOND  = 8'h0c; // Erase block select, blocks 15..8.
    localparam logic [7:0] OFF_STATUS      = 8'h10; // Operating mode and page count.

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int BIT_PROG_REQ  = 0; // Program request.
    localparam int BIT_ERASE_REQ = 1; // Erase request.
    localparam int BIT_PCHECK    = 2; // Program check (verify) bit.
    localparam int BIT_WCHECK    = 3; // Wipe check (verify) bit.
    localparam int BIT_GUARD     = 6; // Write enable guard.
    localparam int BIT_ERR       = 7; // Flash error flag in the second control register.
    localparam int STAT_PAGE_LSB = 8; // Page byte count in the status register.

    // ********************************************************************
    // Values and sizes
    // ********************************************************************
    localparam logic [7:0]  CTRL_RESET    = 8'h00; // Reset value of every control register.
    localparam logic [7:0]  BYTE_ALL_ONES = 8'hff; // Dummy write data for verify.
    localparam logic [1:0]  VERIFY_LOW    = 2'h0;  // Low address bits of a verify address.
    localparam int          PAGE_BYTES    = 128;   // Bytes latched per programming page.
    localparam int          PAGE_AW       = 7;     // Address bits inside one page.
    localparam logic [1:0]  RESP_OKAY     = 2'h0;  // AXI answer for a mapped register.
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;  // AXI answer for an unmapped address.

    // Operating mode, Gray coded along idle, program, verify, erase, erase verify.
    typedef enum logic [2:0] {
        MODE_IDLE  = 3'h0,
        MODE_PROG  = 3'h1,
        MODE_PVER  = 3'h3,
        MODE_ERASE = 3'h2,
        MODE_EVER  = 3'h6
    } mode_t;

    // The bits of the first control register that steer the block.
    typedef struct packed {
        logic guard;    // Write enable guard.
        logic wcheck;   // Erase verify selected.
        logic pcheck;   // Program verify selected.
        logic erase;    // Erase request.
        logic prog;     // Program request.
    } ctrl_t;

endpackage : flash_pe_pkg

// [rtl/flash_program_erase_control.sv]
// Purpose: Mode selection, page latch and protection for on-chip flash program/erase.
// Assumes: CPU flash accesses and system events come from logic on aclk.
// Notes:   Analog pulse timing is left to software; the block only gates the pulses.
`timescale 1ns/1ps

// Notes on behaviour
// - Control registers select exactly one mode.
// - Latch address plus 128 bytes, aligned page.
// - Program only while program request held.
// - Program verify: dummy FF write, word reads.
// - Erase only while erase request held.
// - Erase verify: dummy FF write, longword reads.
// - Reset, watchdog, standby clear all registers.
// - Guard zero blocks program and erase.
// - Unselected blocks are erase protected.
// - Faults during program/erase set error flag.
// - Error keeps settings, aborts, allows verify.
// - Error leaves only by reset, standby; the code also clears it on watchdog.
// - Array reads undefined during requests.
// - Guard set: array reads only in verify.
module flash_program_erase_control
    import flash_pe_pkg::*;
#(
    parameter int          ADDR_W     = 16,            // Flash byte address width.
    parameter int          BLOCKS     = 16,            // Number of erase blocks.
    parameter logic [31:0] UNDEF_DATA = 32'h5a5a_a5a5  // Read value while data is undefined.
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite register slave.
    input  wire logic [7:0]        s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [7:0]        s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // CPU access to the flash array window.
    input  wire logic              fl_req,
    input  wire logic              fl_we,
    input  wire logic [ADDR_W-1:0] fl_addr,
    input  wire logic [7:0]        fl_wdata,
    output logic                   fl_ack,
    output logic [31:0]            fl_rdata,
    // System events.
    input  wire logic              watchdog_reset,
    input  wire logic              hw_standby,
    input  wire logic              low_power_entry,
    input  wire logic              exception_entry,
    input  wire logic              sleep_exec,
    input  wire logic              bus_release,
    // Flash array side.
    input  wire logic [31:0]       arr_rdata,
    output logic [ADDR_W-1:0]      arr_addr,
    output logic                   arr_program,
    output logic                   arr_erase,
    output logic                   arr_verify,
    output logic [BLOCKS-1:0]      arr_block_sel,
    output logic [ADDR_W-1:0]      arr_page_base,
    input  wire logic [PAGE_AW-1:0] arr_byte_idx,
    output logic [7:0]             arr_byte_data
);

    // ********************************************************************
    // State
    // ********************************************************************
    ctrl_t                ctrl_r,    ctrl_nxt;     // First control register.
    logic                 err_r,     err_nxt;      // Flash error flag.
    logic [BLOCKS-1:0]    ebs_r,     ebs_nxt;      // Both erase block selects.
    mode_t                mode_r,    mode_nxt;     // Registered operating mode.
    logic [ADDR_W-1:0]    base_r,    base_nxt;     // Latched page base address.
    logic [PAGE_AW:0]     cnt_r,     cnt_nxt;      // Bytes latched into the page.
    logic [ADDR_W-1:0]    vaddr_r,   vaddr_nxt;    // Verify address from the dummy write.
    logic                 ack_r,     ack_nxt;      // Flash access answer.
    logic [31:0]          frd_r,     frd_nxt;      // Flash read data.
    logic [7:0]           page_mem   [PAGE_BYTES]; // Page latch.
    logic [7:0]           pbyte_r;                 // Byte handed to the array.
    logic                 aw_hold_r, aw_hold_nxt;  // Write address taken.
    logic [7:0]           awa_r,     awa_nxt;      // Held write address.
    logic                 w_hold_r,  w_hold_nxt;   // Write data taken.
    logic [31:0]          wd_r,      wd_nxt;       // Held write data.
    logic [3:0]           ws_r,      ws_nxt;       // Held write strobes.
    logic                 bv_r,      bv_nxt;       // Write answer valid.
    logic [1:0]           br_r,      br_nxt;       // Write answer code.
    logic                 rv_r,      rv_nxt;       // Read answer valid.
    logic [1:0]           rr_r,      rr_nxt;       // Read answer code.
    logic [31:0]          rd_r,      rd_nxt;       // Read answer data.

    // Decoded combinational terms.
    logic                 both_req;   // Both requests set together.
    logic                 pe_active;  // Program or erase pulse applied to the array.
    logic                 fault;      // A protection fault in this cycle.
    logic                 hw_clear;   // Hardware protection clears the registers.
    logic                 page_we;    // Byte stored into the page latch.
    logic                 do_write;   // Register write performed this cycle.
    mode_t                mode_c;     // Mode decoded from the registers.

    // ********************************************************************
    // Mode decode
    // ********************************************************************
    // The mode is decoded from the registers so that a cleared request stops the pulse
    // in the same cycle; the registered copy only feeds the status read.
    always_comb
    begin
        both_req = ctrl_r.prog && ctrl_r.erase;
        mode_c   = MODE_IDLE;
        if (ctrl_r.guard && !err_r && !both_req && ctrl_r.prog)
        begin
            mode_c = MODE_PROG;
        end
        else if (ctrl_r.guard && !err_r && !both_req && ctrl_r.erase && |ebs_r)
        begin
            mode_c = MODE_ERASE;
        end
        else if (ctrl_r.guard && ctrl_r.pcheck)
        begin
            mode_c = MODE_PVER;
        end
        else if (ctrl_r.guard && ctrl_r.wcheck)
        begin
            mode_c = MODE_EVER;
        end
        pe_active = (mode_c == MODE_PROG) || (mode_c == MODE_ERASE);
        fault     = pe_active && ((fl_req && !fl_we) || exception_entry
                    || sleep_exec || bus_release);
        hw_clear  = watchdog_reset || hw_standby || low_power_entry;
    end

    // Array outputs follow the decoded mode; an error aborts at once.
    assign arr_program   = (mode_c == MODE_PROG) && !fault;
    assign arr_erase     = (mode_c == MODE_ERASE) && !fault;
    assign arr_verify    = (mode_c == MODE_PVER) || (mode_c == MODE_EVER);
    assign arr_block_sel = (mode_c == MODE_ERASE) ? ebs_r : '0;
    assign arr_page_base = base_r;
    assign arr_byte_data = pbyte_r;
    assign arr_addr      = arr_verify ? vaddr_r : fl_addr;
    assign fl_ack        = ack_r;
    assign fl_rdata      = frd_r;

    // ********************************************************************
    // Flash access window: page latch, dummy write, guarded reads
    // ********************************************************************
    // Writes with the guard set outside any mode fill the page; FF writes with address bits 1:0 zero in a verify mode set the verify address.
    always_comb
    begin
        base_nxt  = base_r;
        cnt_nxt   = cnt_r;
        vaddr_nxt = vaddr_r;
        page_we   = 1'b0;
        ack_nxt   = fl_req;
        frd_nxt   = frd_r;
        if (fl_req && fl_we && ctrl_r.guard && mode_c == MODE_IDLE)
        begin
            page_we = 1'b1;
            if (cnt_r == '0 || cnt_r[PAGE_AW])
            begin
                base_nxt = {fl_addr[ADDR_W-1:PAGE_AW], {PAGE_AW{1'b0}}};
                cnt_nxt  = (PAGE_AW+1)'(1);
            end
            else
            begin
                cnt_nxt = cnt_r + (PAGE_AW+1)'(1);
            end
        end
        else if (fl_req && fl_we && arr_verify && fl_wdata == BYTE_ALL_ONES
                 && fl_addr[1:0] == VERIFY_LOW)
        begin
            vaddr_nxt = fl_addr;
        end
        if (fl_req && !fl_we)
        begin
            // Reads under a request are undefined, and with the guard set only verify serves.
            if (ctrl_r.prog || ctrl_r.erase || (ctrl_r.guard && !arr_verify))
            begin
                frd_nxt = UNDEF_DATA;
            end
            else
            begin
                frd_nxt = arr_rdata;
            end
        end
        if (!ctrl_r.guard)
        begin
            cnt_nxt = '0;
        end
    end

    // Page latch storage; the array pulls bytes by index.
    always_ff @(posedge aclk)
    begin
        if (page_we)
        begin
            page_mem[fl_addr[PAGE_AW-1:0]] <= fl_wdata;
        end
        pbyte_r <= page_mem[arr_byte_idx];
    end

    // ********************************************************************
    // AXI4-Lite slave
    // ********************************************************************
    // Address and data are held separately; the write lands once both are in.
    always_comb
    begin
        aw_hold_nxt = aw_hold_r;
        awa_nxt     = awa_r;
        w_hold_nxt  = w_hold_r;
        wd_nxt      = wd_r;
        ws_nxt      = ws_r;
        bv_nxt      = bv_r;
        br_nxt      = br_r;
        rv_nxt      = rv_r;
        rr_nxt      = rr_r;
        rd_nxt      = rd_r;
        do_write    = 1'b0;
        if (s_awvalid && s_awready)
        begin
            aw_hold_nxt = 1'b1;
            awa_nxt     = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            w_hold_nxt = 1'b1;
            wd_nxt     = s_wdata;
            ws_nxt     = s_wstrb;
        end
        if (bv_r && s_bready)
        begin
            bv_nxt = 1'b0;
        end
        if (aw_hold_r && w_hold_r && !bv_r)
        begin
            do_write    = 1'b1;
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bv_nxt      = 1'b1;
            br_nxt      = (awa_r == OFF_CTRL_FIRST || awa_r == OFF_CTRL_SECOND
                          || awa_r == OFF_EBS_FIRST || awa_r == OFF_EBS_SECOND
                          || awa_r == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rv_r && s_rready)
        begin
            rv_nxt = 1'b0;
        end
        if (s_arvalid && s_arready)
        begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            rd_nxt = '0;
            if (s_araddr == OFF_CTRL_FIRST)
            begin
                rd_nxt[BIT_GUARD]     = ctrl_r.guard;
                rd_nxt[BIT_WCHECK]    = ctrl_r.wcheck;
                rd_nxt[BIT_PCHECK]    = ctrl_r.pcheck;
                rd_nxt[BIT_ERASE_REQ] = ctrl_r.erase;
                rd_nxt[BIT_PROG_REQ]  = ctrl_r.prog;
            end
            else if (s_araddr == OFF_CTRL_SECOND)
            begin
                rd_nxt[BIT_ERR] = err_r;
            end
            else if (s_araddr == OFF_EBS_FIRST)
            begin
                rd_nxt[7:0] = ebs_r[7:0];
            end
            else if (s_araddr == OFF_EBS_SECOND)
            begin
                rd_nxt[7:0] = ebs_r[BLOCKS-1:8];
            end
            else if (s_araddr == OFF_STATUS)
            begin
                rd_nxt[2:0]                         = mode_r;
                rd_nxt[STAT_PAGE_LSB +: PAGE_AW+1] = cnt_r;
            end
            else
            begin
                rr_nxt = RESP_SLVERR;
            end
        end
    end

    assign s_awready = !aw_hold_r;
    assign s_wready  = !w_hold_r;
    assign s_bvalid  = bv_r;
    assign s_bresp   = br_r;
    assign s_arready = !rv_r;
    assign s_rvalid  = rv_r;
    assign s_rresp   = rr_r;
    assign s_rdata   = rd_r;

    // ********************************************************************
    // Control registers and protection
    // ********************************************************************
    // The error flag is set by hardware only; no software write reaches it.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        ebs_nxt  = ebs_r;
        err_nxt  = err_r || fault;
        mode_nxt = mode_c;
        if (do_write && ws_r[0] && awa_r == OFF_CTRL_FIRST)
        begin
            ctrl_nxt.guard  = wd_r[BIT_GUARD];
            ctrl_nxt.wcheck = wd_r[BIT_WCHECK];
            ctrl_nxt.pcheck = wd_r[BIT_PCHECK];
            ctrl_nxt.erase  = wd_r[BIT_ERASE_REQ];
            ctrl_nxt.prog   = wd_r[BIT_PROG_REQ];
        end
        else if (do_write && ws_r[0] && awa_r == OFF_EBS_FIRST)
        begin
            ebs_nxt[7:0] = wd_r[7:0];
        end
        else if (do_write && ws_r[0] && awa_r == OFF_EBS_SECOND)
        begin
            ebs_nxt[BLOCKS-1:8] = wd_r[BLOCKS-9:0];
        end
        if (hw_clear)
        begin
            ctrl_nxt = ctrl_t'(CTRL_RESET[4:0]);
            ebs_nxt  = '0;
            mode_nxt = MODE_IDLE;
        end
        if (watchdog_reset || hw_standby)
        begin
            err_nxt = 1'b0;
        end
    end

    // All registers of the block except the page latch and pbyte_r; reset is synchronous.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r    <= ctrl_t'(CTRL_RESET[4:0]);
            err_r     <= 1'b0;
            ebs_r     <= '0;
            mode_r    <= MODE_IDLE;
            base_r    <= '0;
            cnt_r     <= '0;
            vaddr_r   <= '0;
            ack_r     <= 1'b0;
            frd_r     <= '0;
            aw_hold_r <= 1'b0;
            awa_r     <= '0;
            w_hold_r  <= 1'b0;
            wd_r      <= '0;
            ws_r      <= '0;
            bv_r      <= 1'b0;
            br_r      <= RESP_OKAY;
            rv_r      <= 1'b0;
            rr_r      <= RESP_OKAY;
            rd_r      <= '0;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            err_r     <= err_nxt;
            ebs_r     <= ebs_nxt;
            mode_r    <= mode_nxt;
            base_r    <= base_nxt;
            cnt_r     <= cnt_nxt;
            vaddr_r   <= vaddr_nxt;
            ack_r     <= ack_nxt;
            frd_r     <= frd_nxt;
            aw_hold_r <= aw_hold_nxt;
            awa_r     <= awa_nxt;
            w_hold_r  <= w_hold_nxt;
            wd_r      <= wd_nxt;
            ws_r      <= ws_nxt;
            bv_r      <= bv_nxt;
            br_r      <= br_nxt;
            rv_r      <= rv_nxt;
            rr_r      <= rr_nxt;
            rd_r      <= rd_nxt;
        end
    end

endmodule : flash_program_erase_control

// [verif/flash_array_model.sv]
// Purpose: Flash array stand-in facing the control block.
// Assumes: Array reads settle within the cycle.
// Notes:   Read data encodes the address, so a wrong verify address shows.
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic        aclk,
    input  wire logic [15:0] arr_addr,
    output logic      [31:0] arr_rdata,
    output logic      [6:0]  arr_byte_idx
);
    // The page latch is scanned one byte a cycle, as the pulse logic would.
    initial arr_byte_idx = 7'h0;
    always @(posedge aclk) arr_byte_idx <= arr_byte_idx + 7'h1;
    // Verify data carries its own address.
    assign arr_rdata = {arr_addr, ~arr_addr};
endmodule : flash_array_model

// [verif/flash_program_erase_control_assertions.sv]
// Purpose: Port-level checks of the flash program/erase control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The sleep fault check excludes clearing events.
`timescale 1ns/1ps
module flash_program_erase_control_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic fl_req,
    input wire logic fl_ack,
    input wire logic watchdog_reset,
    input wire logic hw_standby,
    input wire logic exception_entry,
    input wire logic sleep_exec,
    input wire logic arr_program,
    input wire logic arr_erase,
    input wire logic arr_verify
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ack; fl_req |=> fl_ack; endproperty
    property p_noack; !fl_req |=> !fl_ack; endproperty
    property p_bdone; s_bvalid && s_bready |=> !s_bvalid; endproperty
    property p_one; arr_program |-> !arr_erase && !arr_verify; endproperty
    property p_ver; arr_verify |-> !arr_erase; endproperty
    property p_wdog; watchdog_reset |=> (!arr_program && !arr_erase)[*2]; endproperty
    property p_stby; hw_standby |=> !(arr_program || arr_erase || arr_verify); endproperty
    property p_fault; exception_entry |-> !arr_program && !arr_erase; endproperty
    property p_hold;
        sleep_exec && !watchdog_reset && !hw_standby |=> (!arr_program && !arr_erase)[*4];
    endproperty
    a_ack: assert property (p_ack) else $error("flash access not acknowledged");
    a_noack: assert property (p_noack) else $error("acknowledge without access");
    a_bdone: assert property (p_bdone) else $error("write answer held too long");
    a_one: assert property (p_one) else $error("program beside another mode");
    a_ver: assert property (p_ver) else $error("verify beside erase");
    a_wdog: assert property (p_wdog) else $error("watchdog did not abort");
    a_stby: assert property (p_stby) else $error("standby did not abort");
    a_fault: assert property (p_fault) else $error("fault did not abort");
    a_hold: assert property (p_hold) else $error("request taken under error");
    c_prog: cover property (arr_program);
    c_erase: cover property (arr_erase);
    c_verify: cover property (arr_verify);
endmodule : flash_program_erase_control_assertions

bind flash_program_erase_control flash_program_erase_control_assertions chk_inst (
    .aclk, .aresetn, .s_bvalid, .s_bready, .fl_req, .fl_ack, .watchdog_reset, .hw_standby,
    .exception_entry, .sleep_exec, .arr_program, .arr_erase, .arr_verify);

// [verif/flash_program_erase_control_tb.sv]
// Purpose: Self-checking bench for the flash program/erase control block.
// Assumes: Registers over AXI4-Lite; array stand-in answers at once.
// Notes:   Read results are queued by the driver and compared by a watcher.
`timescale 1ns/1ps
module flash_program_erase_control_tb;
    import flash_pe_pkg::*;
    localparam logic [31:0] UND = 32'h3c3c_c3c3; // Arbitrary undefined-read value.
    logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, fl_req = 1'b0, fl_we = 1'b0;
    logic [5:0] evt = 6'h0; // Faults, watchdog, hardware standby, low power.
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0, fl_wdata = 8'h0, arr_byte_data, page [128];
    logic [31:0] s_wdata = 32'h0, s_rdata, fl_rdata, arr_rdata;
    logic [15:0] fl_addr = 16'h0, va, base, arr_addr, arr_page_base, arr_block_sel;
    logic [1:0] s_bresp, s_rresp;
    logic [6:0] arr_byte_idx, last;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, fl_ack;
    logic arr_program, arr_erase, arr_verify;
    logic [33:0] aq [$], ex;
    logic [32:0] fq [$], fx;
    int n_mismatch = 0, compares = 0, k, b, e;

    always #50 aclk = ~aclk;

    flash_program_erase_control #(.UNDEF_DATA(UND)) flash_program_erase_control_inst (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hf),
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fl_req, .fl_we, .fl_addr,
        .fl_wdata, .fl_ack, .fl_rdata, .exception_entry(evt[0]), .sleep_exec(evt[1]),
        .bus_release(evt[2]), .watchdog_reset(evt[3]), .hw_standby(evt[4]),
        .low_power_entry(evt[5]), .arr_rdata, .arr_addr, .arr_program, .arr_erase,
        .arr_verify, .arr_block_sel, .arr_page_base, .arr_byte_idx, .arr_byte_data);
    flash_array_model flash_array_model_inst (.aclk, .arr_addr, .arr_rdata, .arr_byte_idx);

    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // A wait that runs out of cycles ends the run as a failure.
    task limit;
        if (k == 40)
        begin
            n_mismatch++;
            tally_and_finish;
        end
        #1;
    endtask : limit

    task wr(input logic [7:0] a, input logic [31:0] d);
        aq.push_back({RESP_OKAY, 32'h0});
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        for (k = 0; k < 40; k++)
        begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        s_bready <= 1'b0;
        limit;
    endtask : wr

    task rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        aq.push_back({r, d});
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'h3;
        for (k = 0; k < 40; k++)
        begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        s_rready <= 1'b0;
        limit;
    endtask : rd

    task fa(input logic w, input logic [15:0] a, input logic [7:0] d, input logic c,
            input logic [31:0] x);
        fq.push_back({c, x});
        @(posedge aclk);
        {fl_req, fl_we, fl_addr, fl_wdata} <= {1'b1, w, a, d};
        @(posedge aclk);
        fl_req <= 1'b0;
        #1;
    endtask : fa

    task pulse(input logic [5:0] v);
        @(posedge aclk);
        evt <= v;
        @(posedge aclk);
        evt <= 6'h0;
        #1;
    endtask : pulse

    // Watcher: each answer takes the oldest expectation off its queue.
    always @(posedge aclk)
    begin
        if (s_rvalid && s_rready)
        begin
            ex = aq.pop_front();
            chk(s_rresp, ex[33:32]);
            if (ex[33:32] == RESP_OKAY) chk(s_rdata, ex[31:0]);
        end
        if (s_bvalid && s_bready) chk(s_bresp, 32'(aq.pop_front() >> 32));
        if (fl_ack)
        begin
            fx = fq.pop_front();
            if (fx[32]) chk(fl_rdata, fx[31:0]);
        end
    end

    initial
    begin
        b = $urandom(32'h877d);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CTRL_FIRST, RESP_OKAY, 32'h0);
        rd(OFF_EBS_SECOND, RESP_OKAY, 32'h0);
        rd(8'h20, RESP_SLVERR, 32'h0);
        // A full page of random bytes: every slot is written.
        base = 16'($urandom) & 16'hff80;
        wr(OFF_CTRL_FIRST, 32'h40);
        for (e = 0; e < 128; e++)
        begin
            page[e] = 8'($urandom);
            fa(1'b1, base | 16'(e), page[e], 1'b0, 32'h0);
        end
        chk(arr_page_base, base);
        @(posedge aclk) last = arr_byte_idx;
        repeat (130)
        begin
            @(posedge aclk);
            chk(arr_byte_data, page[last]);
            last = arr_byte_idx;
        end
        fa(1'b0, base, 8'h0, 1'b1, UND);
        wr(OFF_EBS_FIRST, 32'h1);
        wr(OFF_CTRL_FIRST, 32'h2);
        chk(arr_erase, 1'b0);
        wr(OFF_CTRL_FIRST, 32'h1);
        chk(arr_program, 1'b0);
        wr(OFF_CTRL_FIRST, 32'h43);
        chk({arr_program, arr_erase}, 2'h0);
        wr(OFF_CTRL_FIRST, 32'h41);
        chk(arr_program, 1'b1);
        wr(OFF_CTRL_FIRST, 32'h40);
        chk(arr_program, 1'b0);
        wr(OFF_CTRL_FIRST, 32'h41);
        fa(1'b0, base, 8'h0, 1'b1, UND);
        chk(arr_program, 1'b0);
        rd(OFF_CTRL_SECOND, RESP_OKAY, 32'h80);
        rd(OFF_CTRL_FIRST, RESP_OKAY, 32'h41);
        wr(OFF_CTRL_FIRST, 32'h40);
        wr(OFF_CTRL_FIRST, 32'h41);
        chk(arr_program, 1'b0);
        // Both verify modes stay open while the error flag is set.
        va = 16'($urandom) & 16'hfffc;
        for (e = 0; e < 2; e++)
        begin
            wr(OFF_CTRL_FIRST, e ? 32'h48 : 32'h44);
            chk(arr_verify, 1'b1);
            fa(1'b1, va, BYTE_ALL_ONES, 1'b0, 32'h0);
            fa(1'b0, va, 8'h0, 1'b1, {va, ~va});
            va = va ^ 16'h0104;
        end
        pulse(6'h08);
        rd(OFF_CTRL_SECOND, RESP_OKAY, 32'h0);
        // One random block per erase; exception, sleep and bus release each abort it.
        for (e = 0; e < 3; e++)
        begin
            b = $urandom_range(15, 0);
            wr(b < 8 ? OFF_EBS_FIRST : OFF_EBS_SECOND, 32'h1 << (b % 8));
            wr(OFF_CTRL_FIRST, 32'h42);
            chk(arr_erase, 1'b1);
            chk(arr_block_sel, 32'h1 << b);
            pulse(6'h1 << e);
            chk(arr_erase, 1'b0);
            wr(OFF_CTRL_SECOND, 32'h0);
            rd(OFF_CTRL_SECOND, RESP_OKAY, 32'h80);
            pulse(e == 1 ? 6'h10 : 6'h08);
            rd(OFF_CTRL_SECOND, RESP_OKAY, 32'h0);
            rd(OFF_CTRL_FIRST, RESP_OKAY, 32'h0);
        end
        wr(OFF_EBS_FIRST, 32'h1);
        pulse(6'h20);
        rd(OFF_EBS_FIRST, RESP_OKAY, 32'h0);
        tally_and_finish;
    end
endmodule : flash_program_erase_control_tb
